// ==== shared/arsb_pkg.sv ====
// constants, field layouts and carrier types for the audio route, shift and biquad block
package arsb_pkg;

	localparam int SAMPLE_W = 32;
	localparam int SLOT_N = 8;
	localparam int DEST_N = 6;
	localparam int SEC_N = 2;
	localparam int SEC_COEF_N = 5;
	localparam int COEF_N = 10;
	localparam int COEF_FRAC = 28;
	localparam int FRAME_PHASES = 3;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FILT_INDEX = 8'h04;
	localparam logic [7:0] ADDR_BYPASS = 8'h08;
	localparam logic [7:0] ADDR_COEF = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_ROUTE_BASE = 8'h20;

	// field positions
	localparam int CTRL_RATE48_BIT = 0;
	localparam int BYPASS_ALL_LSB = 8;
	localparam int COEF_PTR_LSB = 0;
	localparam int ROUTE_SHIFT_LSB = 8;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_OVR_BIT = 1;

	// reset values
	localparam logic CTRL_RATE48_RESET = 1'b1;
	localparam logic [7:0] BYPASS_RESET = 8'hFF;
	localparam logic signed [31:0] COEF_RESET = 32'h00000000;

	// saturation limits
	localparam logic signed [63:0] SAT_MAX = 64'sh000000007FFFFFFF;
	localparam logic signed [63:0] SAT_MIN = -64'sh0000000080000000;

	typedef logic [4:0] arsb_src_type;
	typedef logic signed [5:0] arsb_shift_type;

	localparam arsb_src_type SRC_ZERO = 5'h00;
	localparam arsb_src_type SRC_HOST_AVG = 5'h01;
	localparam arsb_src_type SRC_HOST_DIFF = 5'h02;
	localparam arsb_src_type SRC_SER_AVG = 5'h03;
	localparam arsb_src_type SRC_SER_DIFF = 5'h04;
	localparam arsb_src_type SRC_PIPE0 = 5'h05;
	localparam arsb_src_type SRC_PIPE1 = 5'h06;
	localparam arsb_src_type SRC_HOST0 = 5'h07;
	localparam arsb_src_type SRC_HOST1 = 5'h08;
	localparam arsb_src_type SRC_SER0 = 5'h09;
	localparam arsb_src_type SRC_SER1 = 5'h0A;
	localparam arsb_src_type SRC_MIC0 = 5'h0B;
	localparam arsb_src_type SRC_MIC1 = 5'h0C;
	localparam arsb_src_type SRC_PACK_PIPE = 5'h0D;
	localparam arsb_src_type SRC_PACK_MIC = 5'h0E;
	localparam arsb_src_type SRC_PACK_REF = 5'h0F;
	localparam arsb_src_type SRC_PACK_ALL = 5'h10;

	// power-up routing, destinations 0..5, all shifts zero
	localparam arsb_src_type ROUTE_RESET [DEST_N] = '{SRC_PIPE0, SRC_PIPE1, SRC_PIPE0, SRC_SER0, SRC_HOST0, SRC_HOST1};
	localparam arsb_shift_type SHIFT_RESET = 6'sh00;

	typedef struct packed {
		logic signed [31:0] host0;
		logic signed [31:0] host1;
		logic signed [31:0] ser0;
		logic signed [31:0] ser1;
		logic signed [31:0] pipe0;
		logic signed [31:0] pipe1;
		logic signed [31:0] mic0;
		logic signed [31:0] mic1;
	} arsb_audio_in_type;

	typedef struct packed {
		logic signed [31:0] usb0;
		logic signed [31:0] usb1;
		logic signed [31:0] ser0;
		logic signed [31:0] ser1;
		logic signed [31:0] mic0;
		logic signed [31:0] mic1;
		logic signed [31:0] ref0;
		logic signed [31:0] ref1;
	} arsb_audio_out_type;

endpackage : arsb_pkg

// ==== core/arsb_core.sv ====
// audio routing crossbar, power-of-two gain and eight two-section biquad slots behind an APB slave
// Behaviour
// [RULE1] route command connects a chosen source index to one of six destinations
// [RULE2] source 0 is zero; 1/3 give channel mean; 2/4 give half difference
// [RULE3] 16kHz microphone on a 48kHz destination repeats each sample three times, unfiltered
// [RULE4] source 7 on destination 0 loops host channel 0 straight back
// [RULE5] source 12 delivers raw microphone channel 1 to the destination
// [RULE6] packed-all on serial outputs interleaves mic, reference and pipeline channels
// [RULE7] positive destination shift left-shifts every sample by that many bits
// [RULE8] negative destination shift right-shifts every sample by its magnitude
// [RULE9] power-up routing is the documented default with zero shift everywhere
// [RULE10] each filter slot is two biquad sections in cascade on its channel
// [RULE11] every slot leaves reset bypassed, passing samples unchanged
// [RULE12] controller enables at most two output slots at once
// [RULE13] filter index selects the slot for later bypass and coefficient writes
// [RULE14] bypass write 1 disables the selected slot, 0 enables it
// [RULE15] coefficient write takes ten words, a1 a2 b0 b1 b2 per section, a0 one
// [RULE16] controller supplies raw coefficients as 32-bit Q28.4 with a1, a2 negated; the engine treats the low 28 bits as fraction (Q4.28)
// [RULE17] input slots run at 16kHz, output slots at the selected output rate
// [RULE18] biquad arithmetic saturates instead of wrapping
// [RULE19] all coefficients are zero after reset
// [RULE20] finishing a coefficient update clears the selected slot's filter state
// [RULE21] right shift for negative shift values is arithmetic
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module arsb_core
	import arsb_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk, // 250 MHz clock
	input wire logic srst, // synchronous reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready, always high
	output logic pslverr, // apb error on unmapped address
	input wire logic frame_stb, // one-cycle 48kHz audio frame pulse, same clock
	input wire arsb_audio_in_type audio_in, // input samples, held between frames
	output arsb_audio_out_type audio_out, // processed samples
	output logic out_done // one-cycle pulse when all pending slots are done
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic signed [31:0] shift_sample(input logic signed [31:0] s, input arsb_shift_type sh);
		logic [5:0] mag;
		mag = 6'(-sh);
		if (sh >= 0)
			return s <<< sh; // see [RULE7]
		return s >>> mag; // see [RULE8] see [RULE21]
	endfunction : shift_sample

	function automatic logic signed [31:0] sat32(input logic signed [63:0] acc);
		logic signed [63:0] t;
		t = acc >>> COEF_FRAC;
		if (t > SAT_MAX)
			return SAT_MAX[31:0]; // see [RULE18]
		if (t < SAT_MIN)
			return SAT_MIN[31:0]; // see [RULE18]
		return t[31:0];
	endfunction : sat32

	function automatic logic signed [31:0] half_sum(input logic signed [31:0] a, input logic signed [31:0] b,
			input logic sub);
		logic signed [32:0] t;
		t = sub ? (33'(a) - 33'(b)) : (33'(a) + 33'(b));
		return t[32:1]; // see [RULE2]
	endfunction : half_sum

	function automatic logic signed [31:0] pick3(input logic [1:0] ph, input logic signed [31:0] a,
			input logic signed [31:0] b, input logic signed [31:0] c);
		case (ph)
			2'h0: return a;
			2'h1: return b;
			default: return c;
		endcase
	endfunction : pick3

	function automatic logic [2:0] lowest_bit(input logic [SLOT_N-1:0] v);
		for (int i = 0; i < SLOT_N; i++) begin
			if (v[i])
				return 3'(i);
		end
		return 3'h0;
	endfunction : lowest_bit

	////////////////////////////////////////////////////////////////////////////
	// state

	logic rate48_reg;
	logic [2:0] filt_idx_reg;
	logic [SLOT_N-1:0] bypass_reg;
	logic [3:0] coef_ptr_reg;
	logic ovr_reg;
	arsb_src_type src_reg [DEST_N];
	arsb_shift_type shift_reg [DEST_N];
	logic signed [31:0] coef_mem [SLOT_N][COEF_N];
	logic [1:0] phase_reg;
	logic signed [31:0] x_in_reg [SLOT_N];
	logic signed [31:0] y_out_reg [SLOT_N];
	logic signed [31:0] st_x1 [SLOT_N][SEC_N];
	logic signed [31:0] st_x2 [SLOT_N][SEC_N];
	logic signed [31:0] st_y1 [SLOT_N][SEC_N];
	logic signed [31:0] st_y2 [SLOT_N][SEC_N];
	logic [SLOT_N-1:0] pending_reg;
	logic busy_reg;
	logic [2:0] eng_slot_reg;
	logic eng_sec_reg;
	logic [2:0] eng_step_reg;
	logic signed [63:0] acc_reg;
	logic signed [31:0] sec_in_reg;
	logic done_reg;
	logic [31:0] prdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	logic apb_wr;
	logic apb_setup;
	logic route_hit;
	logic [2:0] route_idx;
	logic addr_ok;
	logic coef_commit;
	logic [ADDR_W-1:0] route_off;

	assign apb_wr = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign route_off = paddr - ADDR_W'(ADDR_ROUTE_BASE);
	assign route_hit = (paddr >= ADDR_W'(ADDR_ROUTE_BASE)) && (route_off < ADDR_W'(4 * DEST_N))
		&& (paddr[1:0] == 2'h0);
	assign route_idx = route_off[4:2];
	assign addr_ok = route_hit || paddr == ADDR_W'(ADDR_CTRL) || paddr == ADDR_W'(ADDR_FILT_INDEX)
		|| paddr == ADDR_W'(ADDR_BYPASS) || paddr == ADDR_W'(ADDR_COEF) || paddr == ADDR_W'(ADDR_STATUS);
	assign coef_commit = apb_wr && paddr == ADDR_W'(ADDR_COEF) && coef_ptr_reg == 4'(COEF_N - 1);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_reg;

	always_ff @(posedge clk) begin
		if (srst)
			prdata_reg <= 32'h00000000;
		else if (apb_setup) begin
			prdata_reg <= 32'h00000000;
			if (route_hit)
				prdata_reg <= {16'h0000, 2'h0, shift_reg[route_idx], 3'h0, src_reg[route_idx]};
			else if (paddr == ADDR_W'(ADDR_CTRL))
				prdata_reg[CTRL_RATE48_BIT] <= rate48_reg;
			else if (paddr == ADDR_W'(ADDR_FILT_INDEX))
				prdata_reg[2:0] <= filt_idx_reg;
			else if (paddr == ADDR_W'(ADDR_BYPASS)) begin
				prdata_reg[0] <= bypass_reg[filt_idx_reg];
				prdata_reg[BYPASS_ALL_LSB +: SLOT_N] <= bypass_reg;
			end else if (paddr == ADDR_W'(ADDR_COEF))
				prdata_reg[COEF_PTR_LSB +: 4] <= coef_ptr_reg;
			else if (paddr == ADDR_W'(ADDR_STATUS)) begin
				prdata_reg[STATUS_BUSY_BIT] <= busy_reg || (pending_reg != '0);
				prdata_reg[STATUS_OVR_BIT] <= ovr_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk) begin
		if (srst) begin
			rate48_reg <= CTRL_RATE48_RESET;
			filt_idx_reg <= 3'h0;
			bypass_reg <= BYPASS_RESET; // see [RULE11]
			coef_ptr_reg <= 4'h0;
		end else if (apb_wr) begin
			if (paddr == ADDR_W'(ADDR_CTRL))
				rate48_reg <= pwdata[CTRL_RATE48_BIT];
			if (paddr == ADDR_W'(ADDR_FILT_INDEX)) begin
				filt_idx_reg <= pwdata[2:0]; // see [RULE13]
				coef_ptr_reg <= 4'h0;
			end
			if (paddr == ADDR_W'(ADDR_BYPASS))
				bypass_reg[filt_idx_reg] <= pwdata[0]; // see [RULE14]
			if (paddr == ADDR_W'(ADDR_COEF))
				coef_ptr_reg <= coef_commit ? 4'h0 : coef_ptr_reg + 4'h1; // see [RULE15]
		end
	end

	// each word lands at its a1 a2 b0 b1 b2 position; a0 is implied one
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int s = 0; s < SLOT_N; s++)
				for (int c = 0; c < COEF_N; c++)
					coef_mem[s][c] <= COEF_RESET; // see [RULE19]
		end else if (apb_wr && paddr == ADDR_W'(ADDR_COEF))
			coef_mem[filt_idx_reg][coef_ptr_reg] <= pwdata; // see [RULE15]
	end

	// packed-all is a pair setting: its partner channel follows
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int d = 0; d < DEST_N; d++) begin
				src_reg[d] <= ROUTE_RESET[d]; // see [RULE9]
				shift_reg[d] <= SHIFT_RESET; // see [RULE9]
			end
		end else if (apb_wr && route_hit) begin
			src_reg[route_idx] <= pwdata[4:0]; // see [RULE1]
			shift_reg[route_idx] <= pwdata[ROUTE_SHIFT_LSB +: 6];
			if (pwdata[4:0] == SRC_PACK_ALL)
				src_reg[route_idx ^ 3'h1] <= SRC_PACK_ALL; // see [RULE6]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame timing: 16kHz tick is every third 48kHz frame

	logic tick16;
	logic tick_out;

	assign tick16 = frame_stb && phase_reg == 2'h0;
	assign tick_out = rate48_reg ? frame_stb : tick16; // see [RULE17]

	always_ff @(posedge clk) begin
		if (srst)
			phase_reg <= 2'h0;
		else if (frame_stb)
			phase_reg <= (phase_reg == 2'(FRAME_PHASES - 1)) ? 2'h0 : phase_reg + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// crossbar

	logic signed [31:0] routed [DEST_N];
	logic signed [31:0] mic0_hold_reg;
	logic signed [31:0] mic1_hold_reg;
	logic signed [31:0] mic0_now;
	logic signed [31:0] mic1_now;

	// microphones are 16kHz: only a tick brings a new sample, other frames repeat the held one
	assign mic0_now = tick16 ? audio_in.mic0 : mic0_hold_reg; // see [RULE3]
	assign mic1_now = tick16 ? audio_in.mic1 : mic1_hold_reg; // see [RULE3]

	always_ff @(posedge clk) begin
		if (srst) begin
			mic0_hold_reg <= 32'sh00000000;
			mic1_hold_reg <= 32'sh00000000;
		end else if (tick16) begin
			mic0_hold_reg <= audio_in.mic0;
			mic1_hold_reg <= audio_in.mic1;
		end
	end

	// 16kHz sources are held between ticks, so a 48kHz destination repeats each one three times
	for (genvar d = 0; d < DEST_N; d++) begin : g_route
		logic signed [31:0] raw;
		logic ch;
		assign ch = d[0];
		always_comb begin
			raw = 32'sh00000000;
			case (src_reg[d])
				SRC_ZERO: raw = 32'sh00000000; // see [RULE2]
				SRC_HOST_AVG: raw = half_sum(audio_in.host0, audio_in.host1, 1'b0);
				SRC_HOST_DIFF: raw = half_sum(audio_in.host0, audio_in.host1, 1'b1);
				SRC_SER_AVG: raw = half_sum(audio_in.ser0, audio_in.ser1, 1'b0);
				SRC_SER_DIFF: raw = half_sum(audio_in.ser0, audio_in.ser1, 1'b1);
				SRC_PIPE0: raw = audio_in.pipe0;
				SRC_PIPE1: raw = audio_in.pipe1;
				SRC_HOST0: raw = audio_in.host0; // see [RULE4]
				SRC_HOST1: raw = audio_in.host1;
				SRC_SER0: raw = audio_in.ser0;
				SRC_SER1: raw = audio_in.ser1;
				SRC_MIC0: raw = mic0_now; // see [RULE3]
				SRC_MIC1: raw = mic1_now; // see [RULE5] see [RULE3]
				SRC_PACK_PIPE: raw = pick3(phase_reg, audio_in.pipe0, audio_in.pipe1, 32'sh00000000);
				SRC_PACK_MIC: raw = pick3(phase_reg, mic0_now, mic1_now, 32'sh00000000);
				SRC_PACK_REF: raw = pick3(phase_reg, y_out_reg[6], y_out_reg[7], 32'sh00000000);
				SRC_PACK_ALL: raw = ch ? pick3(phase_reg, mic1_now, y_out_reg[7], audio_in.pipe1)
					: pick3(phase_reg, mic0_now, y_out_reg[6], audio_in.pipe0); // see [RULE6]
				default: raw = 32'sh00000000;
			endcase
		end
		assign routed[d] = shift_sample(raw, shift_reg[d]);
	end

	////////////////////////////////////////////////////////////////////////////
	// shared biquad engine, one multiply-accumulate per cycle

	logic [SLOT_N-1:0] tick_set;
	logic signed [31:0] operand;
	logic signed [31:0] coef_now;
	logic signed [63:0] acc_next;
	logic signed [31:0] y_sec;
	logic [3:0] coef_sel;

	assign tick_set = {tick16, tick16, tick16, tick16, tick_out, tick_out, tick_out, tick_out}; // see [RULE17]
	assign coef_sel = eng_sec_reg ? 4'(SEC_COEF_N) + 4'(eng_step_reg) : 4'(eng_step_reg);
	assign coef_now = coef_mem[eng_slot_reg][coef_sel];
	assign acc_next = acc_reg + 64'(coef_now) * 64'(operand);
	assign y_sec = sat32(acc_next); // see [RULE18]

	always_comb begin
		case (eng_step_reg)
			3'h0: operand = st_y1[eng_slot_reg][eng_sec_reg];
			3'h1: operand = st_y2[eng_slot_reg][eng_sec_reg];
			3'h2: operand = sec_in_reg;
			3'h3: operand = st_x1[eng_slot_reg][eng_sec_reg];
			default: operand = st_x2[eng_slot_reg][eng_sec_reg];
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pending_reg <= '0;
			busy_reg <= 1'b0;
			eng_slot_reg <= 3'h0;
			eng_sec_reg <= 1'b0;
			eng_step_reg <= 3'h0;
			acc_reg <= 64'sh0;
			sec_in_reg <= 32'sh0;
			done_reg <= 1'b0;
			for (int s = 0; s < SLOT_N; s++) begin
				x_in_reg[s] <= 32'sh0;
				y_out_reg[s] <= 32'sh0;
				for (int k = 0; k < SEC_N; k++) begin
					st_x1[s][k] <= 32'sh0;
					st_x2[s][k] <= 32'sh0;
					st_y1[s][k] <= 32'sh0;
					st_y2[s][k] <= 32'sh0;
				end
			end
		end else begin
			done_reg <= 1'b0;
			if (!busy_reg && pending_reg != '0) begin
				eng_slot_reg <= lowest_bit(pending_reg);
				if (bypass_reg[lowest_bit(pending_reg)]) begin
					y_out_reg[lowest_bit(pending_reg)] <= x_in_reg[lowest_bit(pending_reg)]; // see [RULE11]
					pending_reg[lowest_bit(pending_reg)] <= 1'b0;
					done_reg <= (pending_reg & (pending_reg - 8'h01)) == '0;
				end else begin
					busy_reg <= 1'b1;
					eng_sec_reg <= 1'b0;
					eng_step_reg <= 3'h0;
					acc_reg <= 64'sh0;
					sec_in_reg <= x_in_reg[lowest_bit(pending_reg)];
				end
			end else if (busy_reg) begin
				acc_reg <= acc_next;
				eng_step_reg <= eng_step_reg + 3'h1;
				if (eng_step_reg == 3'(SEC_COEF_N - 1)) begin
					st_x2[eng_slot_reg][eng_sec_reg] <= st_x1[eng_slot_reg][eng_sec_reg];
					st_x1[eng_slot_reg][eng_sec_reg] <= sec_in_reg;
					st_y2[eng_slot_reg][eng_sec_reg] <= st_y1[eng_slot_reg][eng_sec_reg];
					st_y1[eng_slot_reg][eng_sec_reg] <= y_sec;
					eng_step_reg <= 3'h0;
					acc_reg <= 64'sh0;
					if (!eng_sec_reg) begin
						eng_sec_reg <= 1'b1; // see [RULE10]
						sec_in_reg <= y_sec;
					end else begin
						y_out_reg[eng_slot_reg] <= y_sec;
						pending_reg[eng_slot_reg] <= 1'b0;
						busy_reg <= 1'b0;
						done_reg <= (pending_reg & ~(8'h01 << eng_slot_reg)) == '0;
					end
				end
			end
			// a half-loaded coefficient set must not leave stale history behind
			if (coef_commit) begin
				for (int k = 0; k < SEC_N; k++) begin
					st_x1[filt_idx_reg][k] <= 32'sh0; // see [RULE20]
					st_x2[filt_idx_reg][k] <= 32'sh0;
					st_y1[filt_idx_reg][k] <= 32'sh0;
					st_y2[filt_idx_reg][k] <= 32'sh0;
				end
				if (busy_reg && eng_slot_reg == filt_idx_reg) begin
					busy_reg <= 1'b0;
					pending_reg[filt_idx_reg] <= 1'b0;
				end
			end
			// new frame wins over the engine finishing the same slot
			for (int s = 0; s < SLOT_N; s++) begin
				if (tick_set[s]) begin
					pending_reg[s] <= 1'b1;
					x_in_reg[s] <= (s < 4) ? routed[s] : (s == 4) ? audio_in.mic0 : (s == 5) ? audio_in.mic1
						: routed[s - 2];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// overrun flag, write one to clear, set wins

	always_ff @(posedge clk) begin
		if (srst)
			ovr_reg <= 1'b0;
		else if ((tick_set & pending_reg) != '0)
			ovr_reg <= 1'b1;
		else if (apb_wr && paddr == ADDR_W'(ADDR_STATUS) && pwdata[STATUS_OVR_BIT])
			ovr_reg <= 1'b0;
	end

	assign out_done = done_reg;
	assign audio_out = '{usb0: y_out_reg[0], usb1: y_out_reg[1], ser0: y_out_reg[2], ser1: y_out_reg[3],
		mic0: y_out_reg[4], mic1: y_out_reg[5], ref0: y_out_reg[6], ref1: y_out_reg[7]};

endmodule : arsb_core

`default_nettype wire

// ==== testbench/arsb_core_asserts.sv ====
// port-level checker for arsb_core
`timescale 1ns/100ps
`default_nettype none
module arsb_core_chk
	import arsb_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk, // clock
	input wire logic srst, // synchronous reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [ADDR_W-1:0] paddr, // apb address
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic frame_stb, // frame pulse
	input wire arsb_audio_out_type audio_out, // processed samples
	input wire logic out_done // engine done pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [7:0] since_reg;
	wire logic acc = psel && penable && !pwrite;
	wire logic mapped = paddr[1:0] == 2'h0 && (paddr <= 8'h10 || (paddr >= 8'h20 && paddr <= 8'h34));
	// saturates so a long idle stretch never wraps back into the busy window
	always_ff @(posedge clk) begin
		if (srst || frame_stb)
			since_reg <= 8'h00;
		else if (since_reg != 8'hFF)
			since_reg <= since_reg + 8'h01;
	end
	////////////////////////////////////////////////////////////////
	property p_rst; disable iff (1'b0) srst |=> audio_out == '0 && !out_done; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_done; frame_stb |-> ##[1:100] out_done; endproperty
	a_done: assert property (p_done) else $error("frame not finished in time");
	property p_done_one; out_done |=> !out_done; endproperty
	a_done_one: assert property (p_done_one) else $error("done longer than one cycle");
	property p_idle; since_reg > 8'h64 |-> !out_done; endproperty
	a_idle: assert property (p_idle) else $error("done without a frame");
	property p_hold; since_reg > 8'h64 |-> $stable(audio_out); endproperty
	a_hold: assert property (p_hold) else $error("output moved between frames");
	property p_ready; psel |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("command not accepted");
	property p_err; psel && penable |-> pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("error flag wrong for address");
	property p_byp_rd; acc && paddr == ADDR_BYPASS |-> prdata[31:16] == 16'h0000; endproperty
	a_byp_rd: assert property (p_byp_rd) else $error("bypass read has stray bits");
	property p_coef_rd; acc && paddr == ADDR_COEF |-> prdata < 32'h0000000A; endproperty
	a_coef_rd: assert property (p_coef_rd) else $error("coefficient pointer out of range");
endmodule : arsb_core_chk
bind arsb_core arsb_core_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_stb(frame_stb),
	.audio_out(audio_out), .out_done(out_done));
`default_nettype wire

// ==== testbench/arsb_audio_src.sv ====
// audio stream partner: frame pulse and held input samples
`timescale 1ns/100ps
`default_nettype none
module arsb_audio_src
	import arsb_pkg::*;
(
	input wire logic clk, // clock
	input wire logic send, // request one frame
	input wire arsb_audio_in_type smp, // samples for that frame
	output logic frame_stb, // one-cycle frame pulse
	output arsb_audio_in_type audio_in // samples held until the next frame
);
	initial begin
		frame_stb = 1'b0;
		audio_in = '0;
	end
	always @(posedge clk) begin
		frame_stb <= send;
		if (send)
			audio_in <= smp;
	end
endmodule : arsb_audio_src
`default_nettype wire

// ==== testbench/test_audio_route_shift_biquad.sv ====
// self-checking testbench for arsb_core
`timescale 1ns/100ps
`default_nettype none
module test_audio_route_shift_biquad;
	import arsb_pkg::*;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, frame_stb, out_done, send, slv;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	arsb_audio_in_type audio_in, smp;
	arsb_audio_out_type audio_out;
	int err_count, total_checks, cyc, nfr;
	arsb_core dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_stb(frame_stb),
		.audio_in(audio_in), .audio_out(audio_out), .out_done(out_done));
	arsb_audio_src src (.clk(clk), .send(send), .smp(smp), .frame_stb(frame_stb), .audio_in(audio_in));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// a hang anywhere ends the run as a failure
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task route(input int d, input logic [4:0] s, input logic [5:0] sh);
		apb(ADDR_ROUTE_BASE + 8'(4 * d), 1'b1, {18'h0, sh, 3'h0, s});
	endtask : route
	task frame(input int n);
		int w;
		repeat (n) begin
			@(posedge clk);
			send <= 1'b1;
			@(posedge clk);
			send <= 1'b0;
			w = 0;
			// outputs are looked at mid-cycle, where they are settled
			@(negedge clk);
			while (out_done !== 1'b1 && w < 200) begin
				@(negedge clk);
				w++;
			end
			check({31'h0, out_done}, 32'h1);
			@(posedge clk);
			nfr++;
		end
	endtask : frame
	////////////////////////////////////////////////////////////////
	task t_defaults;
		logic [4:0] dflt [6] = '{5'h05, 5'h06, 5'h05, 5'h09, 5'h07, 5'h08};
		for (int d = 0; d < 6; d++) begin
			apb(ADDR_ROUTE_BASE + 8'(4 * d), 1'b0, 32'h0);
			check(rd, {27'h0, dflt[d]});
		end
		apb(ADDR_BYPASS, 1'b0, 32'h0);
		check(rd, 32'h0000FF01);
		apb(ADDR_CTRL, 1'b0, 32'h0);
		check(rd, 32'h00000001);
		apb(8'h14, 1'b0, 32'h0);
		check({31'h0, slv}, 32'h1);
		check(rd, 32'h0);
		smp = '{32'h100, 32'h40, 32'h300, 32'h100, 32'h11, 32'h22, 32'h555, 32'h777};
		frame(1);
		check(audio_out.usb0, 32'h11);
		check(audio_out.usb1, 32'h22);
		check(audio_out.ser0, 32'h11);
		check(audio_out.ser1, 32'h300);
		check(audio_out.ref0, 32'h100);
		check(audio_out.ref1, 32'h40);
		check(audio_out.mic0, 32'h555);
	endtask : t_defaults
	task t_route;
		logic [4:0] s [7] = '{5'h00, 5'h01, 5'h02, 5'h07, 5'h0C, 5'h03, 5'h04};
		logic [31:0] e [7] = '{32'h0, 32'hA0, 32'h60, 32'h100, 32'h777, 32'h200, 32'h100};
		for (int i = 0; i < 7; i++) begin
			route(0, s[i], 6'h00);
			frame(1);
			check(audio_out.usb0, e[i]);
		end
	endtask : t_route
	task t_shift;
		route(2, 5'h09, 6'h04);
		smp.ser0 = 32'h123;
		frame(1);
		check(audio_out.ser0, 32'h1230);
		route(2, 5'h09, 6'h3E);
		smp.ser0 = 32'hFFFFF000;
		frame(1);
		check(audio_out.ser0, 32'hFFFFFC00);
	endtask : t_shift
	task t_repeat;
		route(3, 5'h0B, 6'h00);
		while (nfr % 3 != 0)
			frame(1);
		for (int i = 0; i < 4; i++) begin
			smp.mic0 = (i == 0) ? 32'hA5 : 32'h5A;
			frame(1);
			check(audio_out.ser1, (i < 3) ? 32'hA5 : 32'h5A);
		end
	endtask : t_repeat
	task t_filter;
		logic [31:0] c [10] = '{0, 0, 32'h10000000, 0, 0, 0, 0, 32'h20000000, 0, 0};
		route(0, 5'h05, 6'h00);
		apb(ADDR_FILT_INDEX, 1'b1, 32'h0);
		for (int i = 0; i < 10; i++)
			apb(ADDR_COEF, 1'b1, c[i]);
		apb(ADDR_COEF, 1'b0, 32'h0);
		check(rd, 32'h0);
		apb(ADDR_BYPASS, 1'b1, 32'h0);
		apb(ADDR_BYPASS, 1'b0, 32'h0);
		check(rd, 32'h0000FE00);
		smp.pipe0 = 32'h100;
		frame(1);
		check(audio_out.usb0, 32'h200);
		smp.pipe0 = 32'h60000000;
		frame(1);
		check(audio_out.usb0, 32'h7FFFFFFF);
		// a second output slot keeps within the two-slot limit
		apb(ADDR_FILT_INDEX, 1'b1, 32'h1);
		apb(ADDR_BYPASS, 1'b1, 32'h0);
		smp.pipe1 = 32'h55;
		frame(1);
		check(audio_out.usb1, 32'h0);
		apb(ADDR_BYPASS, 1'b1, 32'h1);
		frame(1);
		check(audio_out.usb1, 32'h55);
	endtask : t_filter
	task test_done;
		$display("checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	initial begin
		srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
		send = 1'b0; smp = '0; err_count = 0; total_checks = 0; cyc = 0; nfr = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_defaults();
		t_route();
		t_shift();
		t_repeat();
		t_filter();
		test_done();
	end
endmodule : test_audio_route_shift_biquad
`default_nettype wire
